// >>> include/tgc_cfg.svh
// Purpose: offsets, field positions, reset values of the timer gate block
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes:   definitions only
`ifndef TGC_CFG_SVH
`define TGC_CFG_SVH

// register byte offsets
`define TGC_ADR_CTRL   8'h00
`define TGC_ADR_COUNT  8'h04
`define TGC_ADR_PERIOD 8'h08
`define TGC_ADR_WDOG   8'h0c
`define TGC_ADR_CMD    8'h10
`define TGC_ADR_STAT   8'h14

// control register fields
`define TGC_GE      0
`define TGC_POL     1
`define TGC_SS_LO   2
`define TGC_TOG     4
`define TGC_ON      5
`define TGC_WDTE    6
`define TGC_CTRL_RST 8'h00

// watchdog config fields
`define TGC_PS_LO   0
`define TGC_PSA     3
`define TGC_WDOG_RST 4'hf

// period match reset value
`define TGC_PERIOD_RST 8'hff

// command register fields
`define TGC_CMD_CLR   0
`define TGC_CMD_SLEEP 1

// status register fields
`define TGC_ST_GATE 0
`define TGC_ST_TGL  1
`define TGC_ST_WRUN 2
`define TGC_ST_PIN  3
`define TGC_ST_CEN  4

`endif

// >>> include/tgc_pkg.sv
// Purpose: types of the timer gate block
// Assumes: nothing
// Notes:   gate source codes follow the two-bit select field
package tgc_pkg;
  typedef enum logic [1:0] {
    TGC_SRC_PIN,
    TGC_SRC_T0,
    TGC_SRC_T2,
    TGC_SRC_WDT
  } tgc_src_t;
endpackage

// >>> hdl/tgc_gate.sv
// Purpose: gate count enable of a 16-bit timer with four gate sources
// Assumes: 40 MHz sys_clk_i, synchronous active-low reset, classic Wishbone
// Notes:   counter clock and gate pin are asynchronous and get synchronised
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tgc_cfg.svh"

// Operation
// - gate disabled means the timer counts freely on its clock source.
// - gate control acts only while gate_enable_bit is one.
// - active gate: count increments on each rising edge of clock source.
// - inactive gate: count holds its present value.
// - polarity 0 counts on low gate, polarity 1 counts on high gate.
// - source select 00 pin, 01 timer0 overflow, 10 period match, 11 watchdog.
// - polarity applies to whichever source is selected.
// - pin source level drives the gate logic directly.
// - eight-bit timer rollover FFh to 00h sends a pulse to gate logic.
// - period timer resets to 00h after match, pulsing the gate logic.
// - gate enable with source 11 switches the watchdog on.
// - counter_on_bit does not affect watchdog enable for gate use.
// - prescaler bits set time-out; software avoids changing them while running.
// - gate use of the watchdog enables neither reset nor wake.
// - watchdog clear and sleep restart the measured interval.
module tgc_gate
  import tgc_pkg::*;
#(
  parameter int CNT_W    = 16,  // timer count width, multiple of 8
  parameter int WDT_W    = 16,  // watchdog counter width
  parameter int WDT_BASE = 40   // sys clocks per watchdog base tick
) (
  input  wire logic             sys_clk_i,              // system clock
  input  wire logic             rst_n_i,                // sync reset, low
  input  wire logic             wb_cyc_i,               // bus cycle
  input  wire logic             wb_stb_i,               // bus strobe
  input  wire logic             wb_we_i,                // write enable
  input  wire logic [7:0]       wb_adr_i,               // byte address
  input  wire logic [3:0]       wb_sel_i,               // byte lanes
  input  wire logic [31:0]      wb_dat_i,               // write data
  output logic      [31:0]      wb_dat_o,               // read data
  output logic                  wb_ack_o,               // acknowledge
  input  wire logic             counter_clock_source_i, // async count clock
  input  wire logic             gate_input_pin_i,       // async gate pin
  input  wire logic             t0_tick_i,              // timer0 increment
  input  wire logic             t2_tick_i,              // period timer inc
  output logic      [CNT_W-1:0] count_o,                // timer count
  output logic                  count_en_o,             // gate lets count
  output logic                  wdt_run_o,              // watchdog powered
  output logic                  wdt_reset_o             // watchdog reset
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]       gate_control_register;
  logic [7:0]       period_match_register;
  logic [7:0]       eight_bit_timer_count;
  logic [7:0]       period_timer_count;
  logic [3:0]       wdog_cfg;
  logic             cs_s1;
  logic             cs_s2;
  logic             cs_s3;
  logic             gp_s1;
  logic             gp_s2;
  logic             t0_ovf;
  logic             t2_pls;
  logic [15:0]      base_cnt;
  logic [7:0]       pre_cnt;
  logic [WDT_W-1:0] wdt_cnt;
  logic             wdt_ovf;
  logic             src_q;
  logic             tgl;
  logic             src_raw;
  logic             src_pol;
  logic             gate_lvl;
  logic             cnt_ok;
  logic [31:0]      next_rdata;
  logic [CNT_W-1:0] next_count;

  wire logic gate_en  = gate_control_register[`TGC_GE];
  wire logic gate_pol = gate_control_register[`TGC_POL];
  wire logic tog_mode = gate_control_register[`TGC_TOG];
  wire logic cnt_on   = gate_control_register[`TGC_ON];
  wire logic wdt_sw   = gate_control_register[`TGC_WDTE];
  wire tgc_src_t gss  = tgc_src_t'(gate_control_register[`TGC_SS_LO +: 2]);

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  // a request is taken once; ack is high one cycle, then drops
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr     = wb_req & wb_we_i;
  wire logic wr_lo  = wr & wb_sel_i[0];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // control register, low byte lane only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gate_control_register <= `TGC_CTRL_RST;
    end else if (wr_lo && hit(wb_adr_i, `TGC_ADR_CTRL)) begin
      gate_control_register <= wb_dat_i[7:0];
    end
  end

  // period match and watchdog prescaler settings
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      period_match_register <= `TGC_PERIOD_RST;
      wdog_cfg              <= `TGC_WDOG_RST;
    end else begin
      if (wr_lo && hit(wb_adr_i, `TGC_ADR_PERIOD)) begin
        period_match_register <= wb_dat_i[7:0];
      end
      // no guard against a change while running: a spurious capture may follow
      if (wr_lo && hit(wb_adr_i, `TGC_ADR_WDOG)) begin
        wdog_cfg <= wb_dat_i[3:0];
      end
    end
  end

  // clear and sleep commands are write-only strobes
  wire logic wdt_restart = wr_lo & hit(wb_adr_i, `TGC_ADR_CMD) &
                           (wb_dat_i[`TGC_CMD_CLR] | wb_dat_i[`TGC_CMD_SLEEP]);

  // read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `TGC_ADR_CTRL:   next_rdata[7:0] = gate_control_register;
      `TGC_ADR_COUNT:  next_rdata[CNT_W-1:0] = count_o;
      `TGC_ADR_PERIOD: next_rdata[7:0] = period_match_register;
      `TGC_ADR_WDOG:   next_rdata[3:0] = wdog_cfg;
      `TGC_ADR_STAT: begin
        next_rdata[`TGC_ST_GATE] = gate_lvl;
        next_rdata[`TGC_ST_TGL]  = tgl;
        next_rdata[`TGC_ST_WRUN] = wdt_run_o;
        next_rdata[`TGC_ST_PIN]  = gp_s2;
        next_rdata[`TGC_ST_CEN]  = count_en_o;
      end
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for the asynchronous pins

  // cs_s3 only serves the edge detector, which never looks at cs_s1
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
      cs_s3 <= 1'b0;
      gp_s1 <= 1'b0;
      gp_s2 <= 1'b0;
    end else begin
      cs_s1 <= counter_clock_source_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      gp_s1 <= gate_input_pin_i;
      gp_s2 <= gp_s1;
    end
  end

  wire logic clk_rise = cs_s2 & ~cs_s3;

  ////////////////////////////////////////////////////////////////////////
  // eight-bit timer and period timer feeding the gate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      eight_bit_timer_count <= 8'h00;
      t0_ovf                <= 1'b0;
    end else begin
      t0_ovf <= t0_tick_i & (eight_bit_timer_count == 8'hff);
      if (t0_tick_i) begin
        eight_bit_timer_count <= eight_bit_timer_count + 8'h01;
      end
    end
  end

  // match is held until the next increment, which resets and pulses
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      period_timer_count <= 8'h00;
      t2_pls             <= 1'b0;
    end else begin
      t2_pls <= 1'b0;
      if (t2_tick_i) begin
        if (period_timer_count == period_match_register) begin
          period_timer_count <= 8'h00;
          t2_pls             <= 1'b1;
        end else begin
          period_timer_count <= period_timer_count + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog oscillator, prescaler and counter

  // gate use powers it regardless of counter_on_bit
  wire logic wdt_run = wdt_sw | (gate_en & (gss == TGC_SRC_WDT));

  wire logic base_tick = (base_cnt == 16'(WDT_BASE - 1));
  wire logic [7:0] pre_lim = (8'h01 << wdog_cfg[2:0]) - 8'h01;
  // prescaler assigned: divide by 2^rate; otherwise pass every tick
  wire logic pre_tick = base_tick &
                        (!wdog_cfg[`TGC_PSA] || pre_cnt == pre_lim);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      base_cnt  <= 16'h0000;
      pre_cnt   <= 8'h00;
      wdt_cnt   <= '0;
      wdt_ovf   <= 1'b0;
      wdt_run_o <= 1'b0;
    end else begin
      wdt_run_o <= wdt_run;
      wdt_ovf   <= 1'b0;
      if (!wdt_run || wdt_restart) begin
        base_cnt <= 16'h0000;
        pre_cnt  <= 8'h00;
        wdt_cnt  <= '0;
      end else if (base_tick) begin
        base_cnt <= 16'h0000;
        pre_cnt  <= pre_tick ? 8'h00 : pre_cnt + 8'h01;
        if (pre_tick) begin
          wdt_cnt <= wdt_cnt + WDT_W'(1);
          wdt_ovf <= &wdt_cnt;
        end
      end else begin
        base_cnt <= base_cnt + 16'h0001;
      end
    end
  end

  // reset only when software enabled the watchdog itself
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= wdt_ovf & wdt_sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate source selection, polarity and toggle

  always_comb begin
    unique case (gss)
      TGC_SRC_PIN: src_raw = gp_s2;
      TGC_SRC_T0:  src_raw = t0_ovf;
      TGC_SRC_T2:  src_raw = t2_pls;
      TGC_SRC_WDT: src_raw = wdt_ovf;
    endcase
  end

  // polarity acts after the mux, so every source can be inverted
  assign src_pol = gate_pol ? src_raw : ~src_raw;

  // toggle state flips on each active-going edge of the source
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      src_q <= 1'b0;
      tgl   <= 1'b0;
    end else begin
      src_q <= src_pol;
      if (!gate_en || !tog_mode) begin
        tgl <= 1'b0;
      end else if (src_pol && !src_q) begin
        tgl <= ~tgl;
      end
    end
  end

  // the watchdog pulse is one cycle wide, so software picks toggle mode for it
  assign gate_lvl = tog_mode ? tgl : src_pol;
  assign cnt_ok   = ~gate_en | gate_lvl;

  ////////////////////////////////////////////////////////////////////////
  // the 16-bit count

  // software write wins over a count edge in the same cycle
  always_comb begin
    next_count = count_o;
    if (cnt_on && clk_rise && cnt_ok) begin
      next_count = count_o + CNT_W'(1);
    end
    if (wr && hit(wb_adr_i, `TGC_ADR_COUNT)) begin
      for (int b = 0; b < CNT_W / 8; b++) begin
        if (wb_sel_i[b]) begin
          next_count[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // hold is the default: no edge or closed gate keeps the value
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_o    <= '0;
      count_en_o <= 1'b0;
    end else begin
      count_o    <= next_count;
      count_en_o <= cnt_on & cnt_ok;
    end
  end

endmodule

// >>> dv/tgc_gate_props.sv
// Purpose: port assertions of the timer gate
// Assumes: one clock, sync reset low
// Notes:   ctl mirrors acked control writes
`timescale 1ns/1ps
`include "tgc_cfg.svh"
module tgc_gate_props #(
  parameter int CNT_W    = 16, // count width
  parameter int WDT_W    = 16, // wdt width
  parameter int WDT_BASE = 40  // wdt tick
) (
  input wire logic             sys_clk_i,       // clock
  input wire logic             rst_n_i,         // reset
  input wire logic             wb_cyc_i,        // cycle
  input wire logic             wb_stb_i,        // strobe
  input wire logic             wb_we_i,         // write
  input wire logic [7:0]       wb_adr_i,        // address
  input wire logic [3:0]       wb_sel_i,        // lanes
  input wire logic [31:0]      wb_dat_i,        // wdata
  input wire logic             wb_ack_o,        // ack
  input wire logic [CNT_W-1:0] count_o,         // count
  input wire logic             count_en_o,      // enable
  input wire logic             wdt_run_o,       // wdt on
  input wire logic             wdt_reset_o,     // wdt reset
  input wire logic             gate_input_pin_i // pin
);
  logic [7:0] ctl; // control byte
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // lags the register by one edge, as the
  // registered outputs do, so they line up
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctl <= 8'h00;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == `TGC_ADR_CTRL && wb_sel_i[0]) begin
      ctl <= wb_dat_i[7:0];
    end
  end
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pin_quiet;
    ($stable(gate_input_pin_i) && $stable(ctl))[*5];
  endsequence
  AST_ACK_NEXT: assert property (bus_req |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_HOLD: assert property ($past(rst_n_i) && !wb_ack_o && $changed(count_o) |->
    count_o == $past(count_o) + CNT_W'(1)) else $error("count moved other than by one");
  AST_INC_GATE: assert property ($past(rst_n_i) && !wb_ack_o && $changed(count_o) |->
    count_en_o || $past(count_en_o)) else $error("count moved with gate shut");
  AST_WDT_RUN: assert property (wdt_run_o == (ctl[6] || (ctl[0] && ctl[3:2] == 2'b11)))
    else $error("watchdog power wrong");
  AST_NO_WRST: assert property (!ctl[6] |-> !wdt_reset_o)
    else $error("watchdog reset from gate use");
  AST_FREE: assert property (!ctl[0] |-> count_en_o == ctl[5])
    else $error("free run enable wrong");
  AST_PIN: assert property (pin_quiet ##0 (ctl[0] && ctl[4:2] == 3'h0) |->
    count_en_o == (ctl[5] && ctl[1] == gate_input_pin_i)) else $error("pin gate wrong");
endmodule
bind tgc_gate tgc_gate_props #(.CNT_W(CNT_W), .WDT_W(WDT_W), .WDT_BASE(WDT_BASE)) u_props (
  .sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .count_o, .count_en_o, .wdt_run_o, .wdt_reset_o, .gate_input_pin_i);

// >>> dv/tgc_src_model.sv
// Purpose: far side: counter clock, timer strobes
// Assumes: requests change after sys edges
// Notes:   counter clock rests low when idle
`timescale 1ns/1ps
module tgc_src_model (
  input  wire logic sys_clk_i, // clock
  input  wire logic rst_n_i,   // reset
  input  wire logic run_i,     // run clock
  input  wire logic t0_go_i,   // t0 strobes
  input  wire logic t2_go_i,   // t2 strobes
  output logic      cnt_clk_o, // counter clock
  output logic      t0_tick_o, // t0 strobe
  output logic      t2_tick_o  // t2 strobe
);
  logic [2:0] phase; // clock phase
  ////////////////////////////////////////
  // 4 high, 4 low: twice the sync minimum
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !run_i) begin
      phase     <= 3'h0;
      cnt_clk_o <= 1'b0;
    end else begin
      phase     <= phase + 3'h1;
      cnt_clk_o <= phase[2];
    end
  end
  // one strobe per cycle of request
  always_ff @(posedge sys_clk_i) begin
    t0_tick_o <= rst_n_i && t0_go_i;
    t2_tick_o <= rst_n_i && t2_go_i;
  end
endmodule

// >>> dv/tgc_gate_tb.sv
// Purpose: self-checking bench of the timer gate
// Assumes: 40 MHz clock, shortened watchdog
// Notes:   random gate setups, fixed seed
`timescale 1ns/1ps
`include "tgc_cfg.svh"
module tgc_gate_tb
  import tgc_pkg::*;
;
  logic        sys_clk = 1'b0;  // clock
  logic        rst_n   = 1'b0;  // reset
  logic        cyc = 1'b0;      // bus cycle
  logic        we  = 1'b0;      // write
  logic [7:0]  adr = 8'h00;     // address
  logic [3:0]  sel = 4'hf;      // lanes
  logic [31:0] wdat = 32'h0;    // wdata
  logic        pin = 1'b0;      // gate pin
  logic        run = 1'b0;      // clock run
  logic        t0_go = 1'b0;    // t0 request
  logic        t2_go = 1'b0;    // t2 request
  logic [31:0] seed = 32'hbeeb; // xorshift
  logic [31:0] rdat, q, s0, s1; // read data
  logic [15:0] cnt;             // count
  logic        ack, cen, wrun, wrst, cclk, t0t, t2t, p; // misc
  logic [7:0]  c;               // ctrl value
  int          e;               // edge count
  int          num_errors = 0;  // mismatches
  int          n_checks = 0;    // compares
  // 25 ns period
  always #12.5 sys_clk = ~sys_clk;
  tgc_gate #(.WDT_W(4), .WDT_BASE(2)) u_tgc_gate (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .counter_clock_source_i(cclk),
    .gate_input_pin_i(pin), .t0_tick_i(t0t), .t2_tick_i(t2t), .count_o(cnt),
    .count_en_o(cen), .wdt_run_o(wrun), .wdt_reset_o(wrst));
  tgc_src_model u_tgc_src_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .run_i(run),
    .t0_go_i(t0_go), .t2_go_i(t2_go), .cnt_clk_o(cclk), .t0_tick_o(t0t), .t2_tick_o(t2t));
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected count gain, pin source
  function automatic logic [31:0] gain(logic [7:0] k, logic lv, int n);
    if (!k[5] || (k[0] && k[1] != lv)) return 32'h0;
    return 32'(n);
  endfunction
  // one classic cycle; waits for ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    // a missing ack ends the run at the one closing place
    if (n == 20) begin
      num_errors++;
      $display("[ERR] bus ack exp 1 got 0");
      print_verdict();
    end
    r = rdat;
    cyc <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic ticks(logic two, int n);
    if (two) t2_go <= 1'b1;
    else t0_go <= 1'b1;
    repeat (n) @(posedge sys_clk);
    t0_go <= 1'b0;
    t2_go <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // tests need about 1600 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, `TGC_ADR_PERIOD, 32'h0, q);
    chk("period reset", 32'hff, q);
    bus(1'b0, `TGC_ADR_WDOG, 32'h0, q);
    chk("wdog reset", 32'hf, q);
    bus(1'b0, 8'h18, 32'h0, q);
    chk("unmapped", 32'h0, q);
    s1 = xs() & 32'hffff;
    bus(1'b1, `TGC_ADR_COUNT, s1, q);
    bus(1'b0, `TGC_ADR_COUNT, 32'h0, q);
    chk("count load", s1, q);
    $display("registers done");
    // first four: every polarity and pin level
    for (int i = 0; i < 16; i++) begin
      c = (i < 4) ? {5'h04, 1'b0, i[0], 1'b1} : 8'(xs()) & 8'h23;
      s0 = xs();
      p = (i < 4) ? i[1] : s0[0];
      e = 1 + int'(xs() % 8);
      pin <= p;
      bus(1'b1, `TGC_ADR_CTRL, {24'h0, c}, q);
      repeat (6) @(posedge sys_clk);
      bus(1'b0, `TGC_ADR_COUNT, 32'h0, s0);
      run <= 1'b1;
      repeat (8 * e) @(posedge sys_clk);
      run <= 1'b0;
      repeat (6) @(posedge sys_clk);
      bus(1'b0, `TGC_ADR_COUNT, 32'h0, s1);
      chk("count gain", gain(c, p, e), (s1 - s0) & 32'hffff);
    end
    $display("pin gate done");
    // toggle on overflow, then on period match
    bus(1'b1, `TGC_ADR_PERIOD, 32'h3, q);
    for (int k = 0; k < 4; k++) begin
      c = 8'h13 | (8'(k < 2 ? TGC_SRC_T0 : TGC_SRC_T2) << 2);
      if (!k[0]) bus(1'b1, `TGC_ADR_CTRL, {24'h0, c}, q);
      ticks(k >= 2, k < 2 ? 256 : 4);
      bus(1'b0, `TGC_ADR_STAT, 32'h0, q);
      chk("toggle", {31'h0, ~k[0]}, {31'h0, q[`TGC_ST_TGL]});
    end
    $display("toggle sources done");
    bus(1'b1, `TGC_ADR_WDOG, 32'h0, q);
    bus(1'b1, `TGC_ADR_CTRL, 32'h1f, q);
    chk("wdt run", 32'h1, {31'h0, wrun});
    // clear, then sleep: both restart the interval
    for (int k = 1; k < 3; k++) begin
      bus(1'b1, `TGC_ADR_CMD, 32'(k), q);
      bus(1'b0, `TGC_ADR_STAT, 32'h0, s0);
      repeat (14) @(posedge sys_clk);
      bus(1'b0, `TGC_ADR_STAT, 32'h0, s1);
      chk("no overflow yet", s0 & 32'h2, s1 & 32'h2);
      repeat (20) @(posedge sys_clk);
      bus(1'b0, `TGC_ADR_STAT, 32'h0, s1);
      chk("overflow toggles", ~s0 & 32'h2, s1 & 32'h2);
    end
    $display("watchdog gate done");
    print_verdict();
  end
endmodule
